// ===== verilog/bridge_prot.sv
// Protection and diagnostics core of a dual full-bridge DC motor driver.
// Assumes temperature and short detectors are synchronous to clk.
`include "bridge_prot_cfg.svh"

module bridge_prot (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register port
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic [`DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`DATA_W-1:0] reg_rdata,
	// Sensor inputs
	input wire logic temp_prewarn_in,
	input wire logic temp_shutdown_in,
	input wire bridge_prot_pkg::bridge_bits_t short_gnd_det,
	input wire bridge_prot_pkg::bridge_bits_t short_supply_det,
	input wire bridge_prot_pkg::bridge_bits_t cur_limit_hit,
	input wire logic active_low_enable_pin,
	// Driver control
	output logic driver_on,
	output logic bridge_hiz,
	output logic [5:0] current_limit_factor,
	// Diagnostics
	output logic fault_indicator_out,
	output logic irq
);
	logic ctrl_en, next_ctrl_en;
	logic [4:0] run_current_scale, next_run_current_scale;
	logic prewarn_flag, next_prewarn_flag;
	logic overtemp_shutdown_flag, next_overtemp_shutdown_flag;
	bridge_prot_pkg::bridge_bits_t short_gnd, next_short_gnd;
	bridge_prot_pkg::bridge_bits_t short_supply, next_short_supply;
	bridge_prot_pkg::bridge_bits_t load_flag, next_load_flag;
	bridge_prot_pkg::bridge_bits_t limit_flag, next_limit_flag;
	logic next_driver_on, next_fault;
	logic [5:0] next_factor;
	logic [`INT_W-1:0] int_status, next_int_status, int_enable, next_int_enable, int_event;
	logic [`DATA_W-1:0] next_rdata, status_word;
	bridge_prot_pkg::bridge_bits_t confirmed, kind_supply, tripped;
	logic drv_enable;
	logic wr_ctrl;

	// The pin and the software bit both gate the driver; either one restarts short handling.
	assign drv_enable = ctrl_en & ~active_low_enable_pin;
	assign wr_ctrl = reg_wr && reg_addr == `REG_CTRL;

	generate
		for (genvar b = 0; b < 2; b++) begin : g_bridge
			short_link_if link ();
			assign link.det_gnd = short_gnd_det[b];
			assign link.det_supply = short_supply_det[b];
			assign link.hold_off = ~drv_enable;
			assign confirmed[b] = link.confirmed;
			assign kind_supply[b] = link.kind_supply;
			assign tripped[b] = link.tripped;
			short_confirm u_confirm (
				.clk(clk),
				.resetn(resetn),
				.link(link)
			);
		end
	endgenerate

	// Control and flag state.
	always_comb begin
		next_ctrl_en = ctrl_en;
		next_run_current_scale = run_current_scale;
		if (wr_ctrl) begin
			next_ctrl_en = reg_wdata[`CTRL_EN_BIT];
			next_run_current_scale = reg_wdata[`CTRL_SCALE_MSB:`CTRL_SCALE_LSB];
		end
		next_factor = {1'b0, next_run_current_scale} + 6'h01;
		next_prewarn_flag = temp_prewarn_in;
		// Set at the shutdown level, released only once the pre-warning level is left too.
		if (temp_shutdown_in) begin
			next_overtemp_shutdown_flag = 1'b1;
		end else if (!temp_prewarn_in) begin
			next_overtemp_shutdown_flag = 1'b0;
		end else begin
			next_overtemp_shutdown_flag = overtemp_shutdown_flag;
		end
		for (int b = 0; b < 2; b++) begin
			if (!drv_enable) begin
				next_short_gnd[b] = 1'b0;
				next_short_supply[b] = 1'b0;
			end else begin
				next_short_gnd[b] = short_gnd[b] | (confirmed[b] & ~kind_supply[b]);
				next_short_supply[b] = short_supply[b] | (confirmed[b] & kind_supply[b]);
			end
		end
		next_limit_flag = cur_limit_hit;
		next_load_flag = ~cur_limit_hit;
		// Any short on either bridge turns both off, so a confirmation stops the stage at once.
		next_driver_on = drv_enable & ~next_overtemp_shutdown_flag & ~(|tripped) & ~(|confirmed);
		next_fault = next_overtemp_shutdown_flag | (|next_short_gnd) | (|next_short_supply);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_en <= `CTRL_EN_RESET;
			run_current_scale <= `SCALE_RESET;
			current_limit_factor <= {1'b0, `SCALE_RESET} + 6'h01;
			prewarn_flag <= 1'b0;
			overtemp_shutdown_flag <= 1'b0;
			short_gnd <= 2'h0;
			short_supply <= 2'h0;
			limit_flag <= 2'h0;
			load_flag <= 2'h3;
			driver_on <= 1'b0;
			bridge_hiz <= 1'b1;
			fault_indicator_out <= 1'b0;
		end else begin
			ctrl_en <= next_ctrl_en;
			run_current_scale <= next_run_current_scale;
			current_limit_factor <= next_factor;
			prewarn_flag <= next_prewarn_flag;
			overtemp_shutdown_flag <= next_overtemp_shutdown_flag;
			short_gnd <= next_short_gnd;
			short_supply <= next_short_supply;
			limit_flag <= next_limit_flag;
			load_flag <= next_load_flag;
			driver_on <= next_driver_on;
			bridge_hiz <= ~next_driver_on;
			fault_indicator_out <= next_fault;
		end
	end

	// Interrupt state: temperature events are rising edges of the flags held above; short events are the confirmation pulses.
	assign int_event[`INT_PREWARN] = next_prewarn_flag & ~prewarn_flag;
	assign int_event[`INT_OVERTEMP] = next_overtemp_shutdown_flag & ~overtemp_shutdown_flag;
	assign int_event[`INT_SHORT_A] = confirmed[0];
	assign int_event[`INT_SHORT_B] = confirmed[1];

	always_comb begin
		next_int_status = int_status;
		next_int_enable = int_enable;
		if (reg_wr && reg_addr == `REG_INT_CLEAR) begin
			next_int_status = int_status & ~reg_wdata[`INT_W-1:0];
		end
		if (reg_wr && reg_addr == `REG_INT_ENABLE) begin
			next_int_enable = reg_wdata[`INT_W-1:0];
		end
		// An event in the clearing cycle must survive, so the set is applied last.
		next_int_status = next_int_status | int_event;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			int_status <= 4'h0;
			int_enable <= 4'h0;
		end else begin
			int_status <= next_int_status;
			int_enable <= next_int_enable;
		end
	end

	assign irq = |(int_status & int_enable);

	// Read path: data stand in the cycle after the strobe only.
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`ST_PREWARN] = prewarn_flag;
		status_word[`ST_OVERTEMP] = overtemp_shutdown_flag;
		status_word[`ST_GND_A] = short_gnd[0];
		status_word[`ST_GND_B] = short_gnd[1];
		status_word[`ST_SUPPLY_A] = short_supply[0];
		status_word[`ST_SUPPLY_B] = short_supply[1];
		status_word[`ST_LOAD_A] = load_flag[0];
		status_word[`ST_LOAD_B] = load_flag[1];
		status_word[`ST_LIMIT_A] = limit_flag[0];
		status_word[`ST_LIMIT_B] = limit_flag[1];
		status_word[`ST_DRV_ON] = driver_on;
		next_rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				`REG_CTRL: begin
					next_rdata[`CTRL_EN_BIT] = ctrl_en;
					next_rdata[`CTRL_SCALE_MSB:`CTRL_SCALE_LSB] = run_current_scale;
				end
				`REG_STATUS: begin
					next_rdata = status_word;
				end
				`REG_INT_STATUS: begin
					next_rdata[`INT_W-1:0] = int_status;
				end
				`REG_INT_ENABLE: begin
					next_rdata[`INT_W-1:0] = int_enable;
				end
				`REG_LIMIT: begin
					next_rdata[5:0] = current_limit_factor;
				end
				default: begin
					next_rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	scale_write_a: assert property (@(posedge clk) disable iff (!resetn)
		wr_ctrl |=> current_limit_factor == {1'b0, $past(reg_wdata[`CTRL_SCALE_MSB:`CTRL_SCALE_LSB])} + 6'h01)
		else $error("Limit factor does not follow the written scale.");

	ot_shutdown_a: assert property (@(posedge clk) disable iff (!resetn)
		temp_shutdown_in |=> overtemp_shutdown_flag && !driver_on)
		else $error("Shutdown level did not stop the driver.");

	ot_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		overtemp_shutdown_flag && temp_prewarn_in |=> overtemp_shutdown_flag && !driver_on)
		else $error("Overtemperature released before pre-warning cleared.");

	prewarn_flag_a: assert property (@(posedge clk) disable iff (!resetn)
		temp_prewarn_in |=> prewarn_flag)
		else $error("Pre-warning flag not set.");

	short_off_a: assert property (@(posedge clk) disable iff (!resetn)
		(|confirmed) |=> !driver_on && bridge_hiz && (|(short_gnd | short_supply)) == $past(drv_enable))
		else $error("Confirmed short left a bridge running.");

	short_keep_a: assert property (@(posedge clk) disable iff (!resetn)
		short_gnd[0] && drv_enable |=> short_gnd[0])
		else $error("Short flag dropped while driver enabled.");

	disable_hiz_a: assert property (@(posedge clk) disable iff (!resetn)
		!ctrl_en |=> bridge_hiz && !driver_on)
		else $error("Disabled driver not in high impedance.");

	fault_out_a: assert property (@(posedge clk) disable iff (!resetn)
		fault_indicator_out == (overtemp_shutdown_flag | (|short_gnd) | (|short_supply)))
		else $error("Fault output disagrees with fault flags.");

	load_flag_a: assert property (@(posedge clk) disable iff (!resetn)
		cur_limit_hit[1] |=> !load_flag[1] && limit_flag[1])
		else $error("Load flag not cleared while limiting.");

	// The checks below up to pin_off_a, fault_drive_a aside, look one cycle after their cause, once the flag registers have taken it.
	limit_track_a: assert property (@(posedge clk) disable iff (!resetn)
		cur_limit_hit[0] |=> limit_flag[0] && !load_flag[0])
		else $error("Limit flag of bridge A not set while limiting.");

	prewarn_event_a: assert property (@(posedge clk) disable iff (!resetn)
		temp_prewarn_in && !prewarn_flag |=> int_status[`INT_PREWARN])
		else $error("Pre-warning rise did not raise its interrupt bit.");

	ot_release_a: assert property (@(posedge clk) disable iff (!resetn)
		overtemp_shutdown_flag && !temp_prewarn_in && !temp_shutdown_in |=> !overtemp_shutdown_flag)
		else $error("Overtemperature flag kept after both levels cleared.");

	short_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		drv_enable |=> (($past(short_gnd) & ~short_gnd) | ($past(short_supply) & ~short_supply)) == 2'h0)
		else $error("Short flag dropped while the driver was enabled.");

	short_clear_a: assert property (@(posedge clk) disable iff (!resetn)
		!drv_enable |=> short_gnd == 2'h0 && short_supply == 2'h0)
		else $error("Short flag kept after the driver was disabled.");

	short_pair_a: assert property (@(posedge clk) disable iff (!resetn)
		confirmed[1] && kind_supply[1] && drv_enable |=> short_supply[1])
		else $error("Supply short of bridge B not flagged.");

	fault_drive_a: assert property (@(posedge clk) disable iff (!resetn)
		fault_indicator_out |-> !driver_on)
		else $error("Fault shown while the driver runs.");

	pin_off_a: assert property (@(posedge clk) disable iff (!resetn)
		active_low_enable_pin |=> !driver_on && bridge_hiz)
		else $error("Enable pin did not stop the driver.");

	hiz_inverse_a: assert property (@(posedge clk) disable iff (!resetn)
		bridge_hiz == !driver_on)
		else $error("High impedance and driver state disagree.");

	factor_range_a: assert property (@(posedge clk) disable iff (!resetn)
		current_limit_factor != 6'h00 && current_limit_factor <= 6'h20)
		else $error("Limit factor outside one to thirty-two.");

endmodule

// ===== verilog/bridge_prot_cfg.svh
// Constants of the bridge protection block: register offsets, field positions,
// reset values and timing counts. Included by every design file that needs them.
`ifndef BRIDGE_PROT_CFG_SVH
`define BRIDGE_PROT_CFG_SVH

`define CLK_PERIOD_NS 4
`define ADDR_W 8
`define DATA_W 32

// Register byte offsets.
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_INT_STATUS 8'h08
`define REG_INT_CLEAR 8'h0C
`define REG_INT_ENABLE 8'h10
`define REG_LIMIT 8'h14

// Control register fields.
`define CTRL_EN_BIT 0
`define CTRL_SCALE_LSB 8
`define CTRL_SCALE_MSB 12
`define CTRL_EN_RESET 1'h0
`define SCALE_RESET 5'h1F
`define SCALE_DIVISOR 6'h20

// Status register bits.
`define ST_PREWARN 0
`define ST_OVERTEMP 1
`define ST_GND_A 2
`define ST_GND_B 3
`define ST_SUPPLY_A 4
`define ST_SUPPLY_B 5
`define ST_LOAD_A 6
`define ST_LOAD_B 7
`define ST_LIMIT_A 8
`define ST_LIMIT_B 9
`define ST_DRV_ON 10

// Interrupt status, clear and enable bits share this layout.
`define INT_W 4
`define INT_PREWARN 0
`define INT_OVERTEMP 1
`define INT_SHORT_A 2
`define INT_SHORT_B 3

// Short confirmation: retries after the first detection, and the longest gap
// between two detections that still counts as one short event.
`define SHORT_RETRIES 2'h3
`define RETRY_GAP_NS 1000
`define RETRY_GAP_CYC (`RETRY_GAP_NS / `CLK_PERIOD_NS)

`endif

// ===== verilog/bridge_prot_pkg.sv
// Types shared by the bridge protection modules.
// Assumes the constants header is compiled alongside.
package bridge_prot_pkg;

	typedef enum logic [1:0] {
		CONF_IDLE,
		CONF_RETRY,
		CONF_TRIPPED
	} confirm_state_t;

	typedef logic [1:0] bridge_bits_t;

endpackage

// ===== verilog/short_link_if.sv
// Signals between the protection core and one bridge's short confirmation unit.
// Assumes both ends run on the same clock.
interface short_link_if;
	logic det_gnd;
	logic det_supply;
	logic hold_off;
	logic confirmed;
	logic kind_supply;
	logic tripped;

	modport core (output det_gnd, output det_supply, output hold_off,
		input confirmed, input kind_supply, input tripped);
	modport unit (input det_gnd, input det_supply, input hold_off,
		output confirmed, output kind_supply, output tripped);
endinterface

// ===== verilog/short_confirm.sv
// Short confirmation for one bridge: a detection must repeat on each retry
// before the short is taken as real. Assumes detections are one-cycle pulses.
`include "bridge_prot_cfg.svh"

module short_confirm (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Link to the protection core
	short_link_if.unit link
);
	bridge_prot_pkg::confirm_state_t state, next_state;
	logic [1:0] tries, next_tries;
	logic [7:0] gap, next_gap;
	logic kind, next_kind;
	logic confirmed, next_confirmed;
	logic det;

	assign det = link.det_gnd | link.det_supply;

	always_comb begin
		next_state = state;
		next_tries = tries;
		next_gap = gap;
		next_kind = kind;
		next_confirmed = 1'b0;
		case (state)
			bridge_prot_pkg::CONF_IDLE: begin
				if (!link.hold_off && det) begin
					next_state = bridge_prot_pkg::CONF_RETRY;
					next_tries = 2'h0;
					next_gap = 8'h00;
					next_kind = link.det_supply;
				end
			end
			bridge_prot_pkg::CONF_RETRY: begin
				if (link.hold_off) begin
					next_state = bridge_prot_pkg::CONF_IDLE;
				end else if (det) begin
					next_gap = 8'h00;
					next_kind = link.det_supply;
					// A single spike dies out in the gap window; only the third retry trips.
					if (tries == `SHORT_RETRIES - 2'h1) begin
						next_state = bridge_prot_pkg::CONF_TRIPPED;
						next_confirmed = 1'b1;
					end else begin
						next_tries = tries + 2'h1;
					end
				end else if (gap == 8'(`RETRY_GAP_CYC - 1)) begin
					next_state = bridge_prot_pkg::CONF_IDLE;
				end else begin
					next_gap = gap + 8'h01;
				end
			end
			bridge_prot_pkg::CONF_TRIPPED: begin
				if (link.hold_off) begin
					next_state = bridge_prot_pkg::CONF_IDLE;
				end
			end
			default: begin
				next_state = bridge_prot_pkg::CONF_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= bridge_prot_pkg::CONF_IDLE;
			tries <= 2'h0;
			gap <= 8'h00;
			kind <= 1'b0;
			confirmed <= 1'b0;
		end else begin
			state <= next_state;
			tries <= next_tries;
			gap <= next_gap;
			kind <= next_kind;
			confirmed <= next_confirmed;
		end
	end

	assign link.confirmed = confirmed;
	assign link.kind_supply = kind;
	assign link.tripped = (state == bridge_prot_pkg::CONF_TRIPPED);

	retry_count_a: assert property (@(posedge clk) disable iff (!resetn)
		confirmed |-> $past(tries) == 2'h2 && $past(state) == bridge_prot_pkg::CONF_RETRY)
		else $error("Short confirmed without three retries.");

endmodule

// ===== testbench/motor_side_model.sv
// Motor and bridge side of the protection block: short detector pulses and current limiting.
// Assumes the bench holds the burst request fields steady until busy falls.
module motor_side_model (
	// Clock and driver state
	input wire logic clk,
	input wire logic driver_on,
	// Bench commands
	input wire logic [1:0] load_heavy,
	input wire logic burst,
	input wire logic burst_bridge,
	input wire logic burst_supply,
	input wire logic [2:0] burst_len,
	input wire logic [8:0] burst_gap,
	// Detector outputs
	output logic [1:0] gnd_det,
	output logic [1:0] supply_det,
	output logic [1:0] cur_limit_hit,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	// A blocked coil only limits current while the bridge actually drives it.
	assign cur_limit_hit = load_heavy & {2{driver_on}};
	initial begin
		gnd_det = 2'h0;
		supply_det = 2'h0;
		busy = 1'b0;
		forever begin
			@(posedge clk);
			if (burst) begin
				busy <= 1'b1;
				for (int i = 0; i < burst_len; i++) begin
					// An off bridge carries no current, so no short can be seen.
					gnd_det <= (driver_on && !burst_supply) ? (2'h1 << burst_bridge) : 2'h0;
					supply_det <= (driver_on && burst_supply) ? (2'h1 << burst_bridge) : 2'h0;
					@(posedge clk);
					// Back-to-back pulses keep the line high; only a real gap drops it in between.
					if (burst_gap != 9'h0) begin
						gnd_det <= 2'h0;
						supply_det <= 2'h0;
						repeat (burst_gap) @(posedge clk);
					end
				end
				gnd_det <= 2'h0;
				supply_det <= 2'h0;
				busy <= 1'b0;
			end
		end
	end
endmodule

// ===== testbench/motor_bridge_protection_fault_indicator_out_tb.sv
// Self-checking bench of the bridge protection core with a motor side model.
// Assumes the register map and timing of the constants header.
`include "bridge_prot_cfg.svh"
module motor_bridge_protection_fault_indicator_out_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic temp_pw = 1'b0;
	logic temp_sd = 1'b0;
	logic [1:0] gnd_det, supply_det, lim_hit, load_heavy = 2'h0;
	logic pin_n = 1'b0;
	logic driver_on, bridge_hiz, fault, irq, busy;
	logic [5:0] factor;
	logic burst = 1'b0, b_bridge = 1'b0, b_supply = 1'b0;
	logic [2:0] b_len = 3'h0;
	logic [8:0] b_gap = 9'h0;
	logic [31:0] v;
	int error_cnt = 0;
	int num_checks = 0;

	bridge_prot i_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .temp_prewarn_in(temp_pw),
		.temp_shutdown_in(temp_sd), .short_gnd_det(gnd_det), .short_supply_det(supply_det),
		.cur_limit_hit(lim_hit), .active_low_enable_pin(pin_n), .driver_on(driver_on),
		.bridge_hiz(bridge_hiz), .current_limit_factor(factor), .fault_indicator_out(fault), .irq(irq));
	motor_side_model i_motor (.clk(clk), .driver_on(driver_on), .load_heavy(load_heavy), .burst(burst),
		.burst_bridge(b_bridge), .burst_supply(b_supply), .burst_len(b_len), .burst_gap(b_gap),
		.gnd_det(gnd_det), .supply_det(supply_det), .cur_limit_hit(lim_hit), .busy(busy));

	initial begin
		forever #2 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// Checks the driver state outputs and the fault pin together.
	task automatic pins(input logic on, input logic flt);
		chk("driver_on", {31'h0, driver_on}, {31'h0, on});
		chk("bridge_hiz", {31'h0, bridge_hiz}, {31'h0, !on});
		chk("fault", {31'h0, fault}, {31'h0, flt});
	endtask

	task automatic stat_bit(input int b, input logic e);
		rd(`REG_STATUS);
		chk("status bit", {31'h0, v[b]}, {31'h0, e});
	endtask

	task automatic fire(input logic br, input logic sup, input logic [2:0] n, input logic [8:0] g);
		@(posedge clk);
		burst <= 1'b1;
		b_bridge <= br;
		b_supply <= sup;
		b_len <= n;
		b_gap <= g;
		@(posedge clk);
		burst <= 1'b0;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk);
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic t_reset();
		#1;
		pins(1'b0, 1'b0);
		chk("factor", {26'h0, factor}, 32'h20);
		rd(`REG_CTRL);
		chk("ctrl", v, 32'h1F00);
		chk("irq", {31'h0, irq}, 32'h0);
		rd(8'h40);
		chk("unmapped", v, 32'h0);
	endtask

	task automatic t_scale();
		logic [4:0] s;
		for (int k = 0; k < 4; k++) begin
			s = 5'(k * 10 + (k == 3 ? 1 : 0));
			wr(`REG_CTRL, {19'h0, s, 8'h01});
			chk("factor", {26'h0, factor}, 32'(s) + 32'h1);
			rd(`REG_LIMIT);
			chk("limit reg", v, 32'(s) + 32'h1);
		end
		pins(1'b1, 1'b0);
	endtask

	task automatic t_temp();
		wr(`REG_INT_ENABLE, 32'hF);
		@(posedge clk);
		temp_pw <= 1'b1;
		repeat (2) @(posedge clk);
		stat_bit(`ST_PREWARN, 1'b1);
		chk("irq", {31'h0, irq}, 32'h1);
		wr(`REG_INT_CLEAR, 32'h1);
		chk("irq", {31'h0, irq}, 32'h0);
		@(posedge clk);
		temp_sd <= 1'b1;
		repeat (2) @(posedge clk);
		#1 pins(1'b0, 1'b1);
		stat_bit(`ST_OVERTEMP, 1'b1);
		rd(`REG_INT_STATUS);
		chk("int status", v, 32'h2);
		wr(`REG_INT_ENABLE, 32'h0);
		chk("irq masked", {31'h0, irq}, 32'h0);
		rd(`REG_INT_ENABLE);
		chk("int enable", v, 32'h0);
		wr(`REG_INT_CLEAR, 32'hF);
		@(posedge clk);
		temp_sd <= 1'b0;
		repeat (3) @(posedge clk);
		#1 pins(1'b0, 1'b1);
		@(posedge clk);
		temp_pw <= 1'b0;
		repeat (3) @(posedge clk);
		#1 pins(1'b1, 1'b0);
	endtask

	task automatic t_short();
		wr(`REG_INT_ENABLE, 32'hC);
		fire(1'b0, 1'b0, 3'h3, 9'h0);
		repeat (260) @(posedge clk);
		#1 pins(1'b1, 1'b0);
		fire(1'b0, 1'b0, 3'h4, 9'd240);
		pins(1'b0, 1'b1);
		chk("irq short", {31'h0, irq}, 32'h1);
		rd(`REG_STATUS);
		chk("gnd A", {28'h0, v[5:2]}, 32'h1);
		repeat (20) @(posedge clk);
		stat_bit(`ST_GND_A, 1'b1);
		// Restart by disabling and enabling the driver.
		wr(`REG_CTRL, 32'h1F00);
		stat_bit(`ST_GND_A, 1'b0);
		wr(`REG_CTRL, 32'h1F01);
		// The driver state register takes the new enable one edge after the write lands.
		@(posedge clk);
		#1 pins(1'b1, 1'b0);
		fire(1'b1, 1'b1, 3'h4, 9'h0);
		pins(1'b0, 1'b1);
		rd(`REG_STATUS);
		chk("supply B", {28'h0, v[5:2]}, 32'h8);
		@(posedge clk);
		pin_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1 pins(1'b0, 1'b0);
		@(posedge clk);
		pin_n <= 1'b0;
		repeat (3) @(posedge clk);
		#1 pins(1'b1, 1'b0);
		wr(`REG_INT_CLEAR, 32'hF);
	endtask

	task automatic t_load();
		@(posedge clk);
		load_heavy <= 2'h1;
		repeat (3) @(posedge clk);
		rd(`REG_STATUS);
		chk("load and limit", {28'h0, v[9:6]}, 32'h6);
		@(posedge clk);
		load_heavy <= 2'h2;
		repeat (3) @(posedge clk);
		rd(`REG_STATUS);
		chk("load and limit", {28'h0, v[9:6]}, 32'h9);
		@(posedge clk);
		load_heavy <= 2'h0;
		repeat (3) @(posedge clk);
		rd(`REG_STATUS);
		chk("load and limit", {28'h0, v[9:6]}, 32'h3);
	endtask

	// A reset in mid-run must bring back the power-on scale and a stopped driver.
	task automatic t_rerun();
		wr(`REG_CTRL, 32'h0501);
		chk("factor", {26'h0, factor}, 32'h6);
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		#1;
		pins(1'b0, 1'b0);
		chk("factor", {26'h0, factor}, 32'h20);
		rd(`REG_CTRL);
		chk("ctrl", v, 32'h1F00);
	endtask

	task automatic stop_test();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_scale();
		t_temp();
		t_short();
		t_load();
		t_rerun();
		stop_test();
	end

	// The scenarios take under two thousand cycles; this bound leaves ample headroom.
	initial begin
		repeat (50000) @(posedge clk);
		error_cnt++;
		stop_test();
	end
endmodule
